/* design/rs485_link_defs.vh */
// rs485_link_defs.vh: constants of the rs485 node link block
// assumes: included by bare name from every design file of the block
`ifndef RS485_LINK_DEFS_VH
`define RS485_LINK_DEFS_VH

// register byte offsets on apb
`define OFS_CFG        8'h00
`define OFS_MOTOR      8'h04
`define OFS_CUTOFF     8'h08
`define OFS_TXDATA     8'h0c
`define OFS_RXDATA     8'h10
`define OFS_STATUS     8'h14
`define OFS_IRQ_STAT   8'h18
`define OFS_IRQ_MASK   8'h1c

// cfg fields
`define CFG_HPBAUD     2:0
`define CFG_MBBAUD     6:4
`define CFG_NODE       12:8
`define CFG_MODBUS     16

// motor fields
`define MOT_TEMP_EN    0
`define MOT_CUSTOM     1
`define MOT_ID         15:8

// factory defaults: rate code 4 is 38400, node one, host protocol
`define RST_BAUD       3'h4
`define RST_NODE       5'h01
`define RST_CUTOFF     16'hffff

// bit rate codes 0..6, code 7 is not a rate
`define RATE_2400      2400
`define RATE_4800      4800
`define RATE_9600      9600
`define RATE_19200     19200
`define RATE_38400     38400
`define RATE_57600     57600
`define RATE_115200    115200
`define BAUD_CODE_BAD  3'h7

// interrupt event bit positions
`define EV_RX          0
`define EV_FWD         1
`define EV_OVT         2
`define EV_REJ         3
`define EV_FERR        4
`define EV_OVR         5
`define EV_W           6

// character width on the wire
`define DATA_BITS      8

`endif

/* design/rs485_node_link.v */
// rs485_node_link.v: rs485 node port of a motor drive, apb register slave
// assumes: apb master on CLOCK_I, RXD_I and the drive pins are asynchronous,
// THERM_OHM_I comes from a converter clocked by CLOCK_I
`include "rs485_link_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rs485_node_link #(
    parameter CLK_HZ   = 200000000,  // lower it in simulation to shorten bits
    parameter GAP_BITS = 20          // idle bit times that end a packet
) (
    // clock and reset
    input  wire        CLOCK_I,
    input  wire        RST_I,
    // apb slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [7:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // rs485 line
    input  wire        RXD_I,
    output wire        TXD_O,
    output wire        TXD_OE_O,
    // drive and motor
    input  wire        DRIVE_EN_I,
    input  wire [15:0] THERM_OHM_I,
    input  wire        THERM_SW_OPEN_I,
    // status and shared settings
    output reg         IRQ_O,
    output reg         OVERTEMP_O,
    output reg  [2:0]  RS232_BAUD_O,
    output reg  [4:0]  NODE_ADDR_O,
    output reg         MODBUS_O,
    output reg  [7:0]  MOTOR_ID_O,
    output reg         CUSTOM_MOTOR_O
);
    // cycles per bit for a rate code; bad codes never reach here
    function [16:0] baud_div;
        input [2:0] code;
        reg   [31:0] r;
        begin
            case (code)
                3'h0:    r = CLK_HZ / `RATE_2400;
                3'h1:    r = CLK_HZ / `RATE_4800;
                3'h2:    r = CLK_HZ / `RATE_9600;
                3'h3:    r = CLK_HZ / `RATE_19200;
                3'h4:    r = CLK_HZ / `RATE_38400;
                3'h5:    r = CLK_HZ / `RATE_57600;
                default: r = CLK_HZ / `RATE_115200;
            endcase
            baud_div = r[16:0];
        end
    endfunction

    // settings
    reg [2:0]  hp_baud;       // host protocol rate, shared with rs232
    reg [2:0]  mb_baud;       // modbus rate
    reg [4:0]  node;          // own node address
    reg        modbus;        // 0 host protocol, 1 modbus slave
    reg        temp_en;       // temperature sensor in use
    reg [15:0] cutoff;        // ptc cut-off resistance
    reg [`EV_W-1:0] irq_stat; // sticky events
    reg [`EV_W-1:0] irq_mask; // 1 lets the event through

    // synchronisers, first stage read only by the second
    reg [1:0] rxd_s;
    reg [1:0] den_s;
    reg [1:0] sw_s;

    // datapath state
    reg [16:0] cur_div;       // cycles per bit now in use
    reg [16:0] tick_cnt;      // bit time divider
    reg        bit_tick;      // one pulse per bit time
    reg [5:0]  gap;           // idle bit times seen
    reg        pkt_start;     // next byte is an address byte
    reg        fwd;           // current packet passes through
    reg [7:0]  rx_hold;       // last locally received byte
    reg        pend;          // software byte waiting for the line
    reg [7:0]  pend_byte;
    reg        tx_go;         // start pulse to the transmitter
    reg [7:0]  tx_byte;
    reg [`EV_W-1:0] ev;       // events of this cycle

    wire [7:0] rx_data;
    wire       rx_done;
    wire       rx_ferr;
    wire       rx_busy;
    wire       tx_busy;

    // apb strobes: pready is always high, so each access lasts one cycle
    wire setup = PSEL_I & ~PENABLE_I;
    wire wr    = PSEL_I & PENABLE_I & PWRITE_I;

    // routing of the byte just received
    wire addr_hit  = (rx_data == {3'h0, node});
    wire route_fwd = ~modbus & (pkt_start ? ~addr_hit : fwd);
    wire fwd_now   = rx_done & route_fwd;
    wire over      = temp_en & ((THERM_OHM_I > cutoff) | sw_s[1]);

    reg        next_go;
    reg [7:0]  next_byte;
    reg [31:0] next_rdata;
    reg        next_err;

    // input synchronisers
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rxd_s <= 2'h3;
            den_s <= 2'h0;
            sw_s  <= 2'h0;
        end else begin
            rxd_s <= {rxd_s[0], RXD_I};
            den_s <= {den_s[0], DRIVE_EN_I};
            sw_s  <= {sw_s[0], THERM_SW_OPEN_I};
        end
    end

    // character engines, eight data bits each way
    rs485_uart_rx #(.DATA_BITS(`DATA_BITS)) u_rx (
        .clk_i  (CLOCK_I),
        .rst_i  (RST_I),
        .rxd_i  (rxd_s[1]),
        .div_i  (cur_div),
        .data_o (rx_data),
        .done_o (rx_done),
        .ferr_o (rx_ferr),
        .busy_o (rx_busy)
    );

    rs485_uart_tx #(.DATA_BITS(`DATA_BITS)) u_tx (
        .clk_i   (CLOCK_I),
        .rst_i   (RST_I),
        .start_i (tx_go),
        .data_i  (tx_byte),
        .div_i   (cur_div),
        .txd_o   (TXD_O),
        .oe_o    (TXD_OE_O),
        .busy_o  (tx_busy)
    );

    // transmit arbitration: forwarded bytes first, software byte when no forwarded packet is running
    always @* begin
        next_go   = 1'b0;
        next_byte = tx_byte;
        if (fwd_now && !tx_busy && !tx_go) begin
            next_go   = 1'b1;
            next_byte = rx_data;                     // sent unchanged
        end else if (pend && !tx_busy && !tx_go && (pkt_start || !fwd)) begin
            next_go   = 1'b1;
            next_byte = pend_byte;
        end
    end

    // event collection for the sticky status
    always @* begin
        ev = {`EV_W{1'b0}};
        ev[`EV_RX]   = rx_done & ~route_fwd;
        ev[`EV_FWD]  = fwd_now & ~tx_busy & ~tx_go;
        ev[`EV_OVT]  = over & ~OVERTEMP_O;
        ev[`EV_REJ]  = wr & (PADDR_I == `OFS_MOTOR) & den_s[1];
        ev[`EV_FERR] = rx_ferr;
        // forward byte lost to a busy line, or a second software byte
        ev[`EV_OVR]  = (fwd_now & (tx_busy | tx_go))
                     | (wr & (PADDR_I == `OFS_TXDATA) & pend);
    end

    // bit time divider and packet gap detector
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            cur_div   <= 17'h0;               // loaded on the first edge
            tick_cnt  <= 17'h0;
            bit_tick  <= 1'b0;
            gap       <= 6'h0;
            pkt_start <= 1'b1;
            fwd       <= 1'b0;
        end else begin
            cur_div <= baud_div(modbus ? mb_baud : hp_baud);
            bit_tick <= (tick_cnt == cur_div - 17'h1);
            if (tick_cnt >= cur_div - 17'h1)
                tick_cnt <= 17'h0;
            else
                tick_cnt <= tick_cnt + 17'h1;
            if (rx_busy || rx_done || rx_ferr) begin
                gap <= 6'h0;                          // line active
            end else if (bit_tick && gap != GAP_BITS[5:0]) begin
                gap <= gap + 6'h1;
                if (gap == GAP_BITS[5:0] - 6'h1)
                    pkt_start <= 1'b1;                // quiet line ends packet
            end
            // the address byte decides the route of the whole packet
            if (rx_done && pkt_start) begin
                pkt_start <= 1'b0;
                fwd       <= ~modbus & ~addr_hit;
            end
        end
    end

    // receive holding, transmit start and pending software byte
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_hold   <= 8'h0;
            pend      <= 1'b0;
            pend_byte <= 8'h0;
            tx_go     <= 1'b0;
            tx_byte   <= 8'h0;
        end else begin
            tx_go   <= next_go;
            tx_byte <= next_byte;
            if (rx_done && !route_fwd)
                rx_hold <= rx_data;
            if (next_go && !fwd_now)
                pend <= 1'b0;
            else if (wr && PADDR_I == `OFS_TXDATA && !pend) begin
                pend      <= 1'b1;
                pend_byte <= PWDATA_I[7:0];
            end
        end
    end

    // configuration registers written over apb
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            hp_baud        <= `RST_BAUD;
            mb_baud        <= `RST_BAUD;
            node           <= `RST_NODE;
            modbus         <= 1'b0;
            temp_en        <= 1'b0;
            cutoff         <= `RST_CUTOFF;
            MOTOR_ID_O     <= 8'h0;
            CUSTOM_MOTOR_O <= 1'b0;
            irq_mask       <= {`EV_W{1'b0}};
        end else if (wr) begin
            case (PADDR_I)
                `OFS_CFG: begin
                    // code 7 is no rate, so that field keeps its value
                    if (PWDATA_I[`CFG_HPBAUD] != `BAUD_CODE_BAD)
                        hp_baud <= PWDATA_I[`CFG_HPBAUD];
                    if (PWDATA_I[`CFG_MBBAUD] != `BAUD_CODE_BAD)
                        mb_baud <= PWDATA_I[`CFG_MBBAUD];
                    node   <= PWDATA_I[`CFG_NODE];
                    modbus <= PWDATA_I[`CFG_MODBUS];
                end
                `OFS_MOTOR: begin
                    if (!den_s[1]) begin
                        temp_en        <= PWDATA_I[`MOT_TEMP_EN];
                        CUSTOM_MOTOR_O <= PWDATA_I[`MOT_CUSTOM];
                        MOTOR_ID_O     <= PWDATA_I[`MOT_CUSTOM] ?
                                          8'h0 : PWDATA_I[`MOT_ID];
                    end
                end
                `OFS_CUTOFF:   cutoff   <= PWDATA_I[15:0];
                `OFS_IRQ_MASK: irq_mask <= PWDATA_I[`EV_W-1:0];
                default: ;                              // others have no store
            endcase
        end
    end

    // sticky status: an event in the clearing cycle stays set
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_stat     <= {`EV_W{1'b0}};
            IRQ_O        <= 1'b0;
            OVERTEMP_O   <= 1'b0;
            RS232_BAUD_O <= `RST_BAUD;
            NODE_ADDR_O  <= `RST_NODE;
            MODBUS_O     <= 1'b0;
        end else begin
            if (wr && PADDR_I == `OFS_IRQ_STAT)
                irq_stat <= (irq_stat & ~PWDATA_I[`EV_W-1:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            IRQ_O        <= |(irq_stat & irq_mask);
            OVERTEMP_O   <= over;
            RS232_BAUD_O <= hp_baud;
            NODE_ADDR_O  <= node;
            MODBUS_O     <= modbus;
        end
    end

    // read mux, sampled in the setup cycle
    always @* begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (PADDR_I)
            `OFS_CFG: begin
                next_rdata[`CFG_HPBAUD] = hp_baud;
                next_rdata[`CFG_MBBAUD] = mb_baud;
                next_rdata[`CFG_NODE]   = node;
                next_rdata[`CFG_MODBUS] = modbus;
            end
            `OFS_MOTOR: begin
                next_rdata[`MOT_TEMP_EN] = temp_en;
                next_rdata[`MOT_CUSTOM]  = CUSTOM_MOTOR_O;
                next_rdata[`MOT_ID]      = MOTOR_ID_O;
            end
            `OFS_CUTOFF:   next_rdata[15:0] = cutoff;
            `OFS_TXDATA:   next_rdata[7:0]  = pend_byte;
            `OFS_RXDATA:   next_rdata[7:0]  = rx_hold;
            `OFS_STATUS:   next_rdata[5:0]  = {den_s[1], OVERTEMP_O, fwd,
                                               pkt_start, pend, tx_busy};
            `OFS_IRQ_STAT: next_rdata[`EV_W-1:0] = irq_stat;
            `OFS_IRQ_MASK: next_rdata[`EV_W-1:0] = irq_mask;
            default:       next_err = 1'b1;          // unmapped: error, zero data
        endcase
    end

    // apb answer registers, valid through the access cycle
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            PRDATA_O  <= 32'h0;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= 1'b1;
            if (setup) begin
                PRDATA_O  <= PWRITE_I ? 32'h0 : next_rdata;
                PSLVERR_O <= next_err;
            end
        end
    end
endmodule
`default_nettype wire

/* design/rs485_uart_rx.v */
// rs485_uart_rx.v: one-character receiver, start, 8 data lsb first, stop
// assumes: rxd already synchronised, div is clock cycles per bit, div >= 4
`include "rs485_link_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rs485_uart_rx #(
    parameter DATA_BITS = `DATA_BITS
) (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // line and rate
    input  wire                 rxd_i,
    input  wire [16:0]          div_i,
    // character out
    output reg  [DATA_BITS-1:0] data_o,
    output reg                  done_o,
    output reg                  ferr_o,
    output wire                 busy_o
);
    localparam [3:0] S_IDLE = 4'h1, S_START = 4'h2, S_DATA = 4'h4, S_STOP = 4'h8;

    reg [3:0]  state;   // one-hot receive state
    reg [16:0] cnt;     // cycles inside the bit
    reg [3:0]  nbit;    // data bits taken

    assign busy_o = (state != S_IDLE);

    // sample each bit in its middle
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state  <= S_IDLE;
            cnt    <= 17'h0;
            nbit   <= 4'h0;
            data_o <= {DATA_BITS{1'b0}};
            done_o <= 1'b0;
            ferr_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            ferr_o <= 1'b0;
            cnt    <= cnt + 17'h1;
            case (state)
                S_IDLE: begin
                    cnt <= 17'h0;
                    if (!rxd_i) state <= S_START;     // falling edge: start bit
                end
                S_START: begin
                    if (cnt == (div_i >> 1)) begin
                        cnt   <= 17'h0;
                        nbit  <= 4'h0;
                        // a short glitch is not a start bit
                        state <= rxd_i ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (cnt == div_i - 17'h1) begin
                        cnt    <= 17'h0;
                        data_o <= {rxd_i, data_o[DATA_BITS-1:1]};
                        nbit   <= nbit + 4'h1;
                        if (nbit == DATA_BITS - 1) state <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (cnt == div_i - 17'h1) begin
                        done_o <= rxd_i;              // good stop bit
                        ferr_o <= !rxd_i;             // framing error, byte dropped
                        state  <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* design/rs485_uart_tx.v */
// rs485_uart_tx.v: one-character transmitter with driver enable
// assumes: start only while busy is low, div is clock cycles per bit
`include "rs485_link_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rs485_uart_tx #(
    parameter DATA_BITS = `DATA_BITS
) (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // character in
    input  wire                 start_i,
    input  wire [DATA_BITS-1:0] data_i,
    input  wire [16:0]          div_i,
    // line
    output reg                  txd_o,
    output reg                  oe_o,
    output wire                 busy_o
);
    reg [DATA_BITS:0] sh;   // data then stop bit
    reg [16:0]        cnt;  // cycles inside the bit
    reg [3:0]         nbit; // bits already put on the line

    assign busy_o = oe_o;

    // shift out one bit per div cycles, driver on for the whole frame
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_o <= 1'b1;
            oe_o  <= 1'b0;
            sh    <= {(DATA_BITS+1){1'b1}};
            cnt   <= 17'h0;
            nbit  <= 4'h0;
        end else if (!oe_o) begin
            if (start_i) begin
                txd_o <= 1'b0;                        // start bit
                oe_o  <= 1'b1;
                sh    <= {1'b1, data_i};
                cnt   <= 17'h0;
                nbit  <= 4'h0;
            end
        end else if (cnt == div_i - 17'h1) begin
            cnt <= 17'h0;
            if (nbit == DATA_BITS + 1) begin
                oe_o  <= 1'b0;                        // stop bit done, release bus
                txd_o <= 1'b1;
            end else begin
                txd_o <= sh[0];
                sh    <= {1'b1, sh[DATA_BITS:1]};
                nbit  <= nbit + 4'h1;
            end
        end else begin
            cnt <= cnt + 17'h1;
        end
    end
endmodule
`default_nettype wire

/* testbench/rs485_host_model.sv */
// rs485_host_model.sv: host on the rs485 line, sends packets, gathers echoes
// assumes: bit time in clock cycles, start, eight data, one stop
`timescale 1ns/1ps
`default_nettype none
module rs485_host_model #(
    parameter int DIV = 30  // cycles per bit of the echo receiver
) (
    // clock and line
    input  wire logic clk_i,
    output var logic  rxd_o,
    input  wire logic txd_i,
    input  wire logic txd_oe_i
);
    logic [7:0] got_q [$];  // characters the node drove
    logic [7:0] shift;      // echo being gathered
    initial rxd_o = 1'b1;   // biased line idles at mark
    // one character, extra idle bit so a resend never overruns
    task automatic send(input logic [7:0] b, input int d);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (d) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= b[i];
            repeat (d) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (2 * d) @(posedge clk_i);
    endtask
    // target address leads every packet
    task automatic packet(input logic [7:0] a, input logic [7:0] p, input int d);
        send(a, d);
        send(p, d);
    endtask
    // sample echoes mid-bit from the start edge
    initial forever begin
        @(posedge clk_i iff (txd_oe_i === 1'b1 && txd_i === 1'b0));
        repeat (DIV / 2) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
            repeat (DIV) @(posedge clk_i);
            shift[k] = txd_i;
        end
        got_q.push_back(shift);
        repeat (DIV) @(posedge clk_i);
    end
endmodule
`default_nettype wire

/* testbench/rs485_node_link_props.sv */
// rs485_node_link_props.sv: port checker of the rs485 node link
// assumes: bound to rs485_node_link, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rs485_node_link_props (
    // clock, reset, apb
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    // line, drive and settings
    input wire logic        TXD_O,
    input wire logic        TXD_OE_O,
    input wire logic        DRIVE_EN_I,
    input wire logic [2:0]  RS232_BAUD_O,
    input wire logic [4:0]  NODE_ADDR_O,
    input wire logic        MODBUS_O,
    input wire logic [7:0]  MOTOR_ID_O,
    input wire logic        CUSTOM_MOTOR_O
);
    // completed writes, all and to the settings word
    wire wr = PSEL_I && PENABLE_I && PWRITE_I;
    wire cfg_wr = wr && PADDR_I == 8'h00;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // local copy of the word, a slip in the rate or node field shows
    property p_cfg;
        logic [31:0] d;
        (cfg_wr && PWDATA_I[2:0] != 3'h7, d = PWDATA_I) |=> ##1
            RS232_BAUD_O == d[2:0] && NODE_ADDR_O == d[12:8];
    endproperty
    a_reset_dflt: assert property ($fell(RST_I) |-> RS232_BAUD_O == 3'h4 && NODE_ADDR_O == 5'h01)
        else $error("settings not at defaults after reset");
    a_bad_rate: assert property (cfg_wr && PWDATA_I[2:0] == 3'h7 |=> ##1 $stable(RS232_BAUD_O))
        else $error("rate code seven was taken");
    a_cfg_fields: assert property (p_cfg)
        else $error("rate or node not taken");
    a_mode_bit: assert property ($rose(MODBUS_O) |-> $past(cfg_wr, 2))
        else $error("mode changed without a write");
    a_custom_zero: assert property (CUSTOM_MOTOR_O |-> MOTOR_ID_O == 8'h00)
        else $error("custom motor with nonzero id");
    a_motor_lock: assert property (DRIVE_EN_I [*4] ##0 (wr && PADDR_I == 8'h04)
        |=> $stable(MOTOR_ID_O) [*2])
        else $error("motor changed while enabled");
    a_start_low: assert property ($rose(TXD_OE_O) |-> !TXD_O)
        else $error("character not opened by start bit");
    a_idle_mark: assert property (!TXD_OE_O |-> TXD_O)
        else $error("line not at mark while released");
    cover property (cfg_wr && PWDATA_I[2:0] == 3'h7);
    cover property ($rose(TXD_OE_O));
    cover property ($rose(CUSTOM_MOTOR_O));
endmodule
bind rs485_node_link rs485_node_link_props chk_u (.CLOCK_I, .RST_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .TXD_O, .TXD_OE_O, .DRIVE_EN_I, .RS232_BAUD_O,
    .NODE_ADDR_O, .MODBUS_O, .MOTOR_ID_O, .CUSTOM_MOTOR_O);
`default_nettype wire

/* testbench/rs485_node_link_tb_top.sv */
// rs485_node_link_tb_top.sv: self-checking bench of the rs485 node link
// assumes: host model on the line, apb driven here, short bit times
`timescale 1ns/1ps
`default_nettype none
module rs485_node_link_tb_top;
    localparam int SLOW = 30;  // cycles per bit at 38400
    localparam int FAST = 10;  // cycles per bit at 115200
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        drv = 1'b0;      // drive enabled pin
    logic [15:0] ohm = 16'h0000;  // thermistor reading
    logic        sw_open = 1'b0;  // thermal switch pin
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, txd, txd_oe, irq, ovt, mb, cust;
    wire  [2:0]  baud;
    wire  [4:0]  node;
    wire  [7:0]  mid;
    logic [31:0] rd;   // last read data
    logic        err;  // last slave error
    int          bad_count = 0;
    int          checked = 0;
    // settings words beside the {rate, node} they should leave
    logic [31:0] row_cfg [8] = '{32'h0, 32'hb01, 32'h1f02, 32'h503,
                                 32'h104, 32'h205, 32'h306, 32'h907};
    logic [7:0]  row_exp [8] = '{8'h00, 8'h2b, 8'h5f, 8'h65, 8'h81, 8'ha2, 8'hc3, 8'hc9};
    always #2.5 clk = ~clk;
    rs485_node_link #(.CLK_HZ(1152000), .GAP_BITS(4)) dut_u (
        .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .RXD_I(rxd), .TXD_O(txd), .TXD_OE_O(txd_oe),
        .DRIVE_EN_I(drv), .THERM_OHM_I(ohm), .THERM_SW_OPEN_I(sw_open), .IRQ_O(irq),
        .OVERTEMP_O(ovt), .RS232_BAUD_O(baud), .NODE_ADDR_O(node), .MODBUS_O(mb),
        .MOTOR_ID_O(mid), .CUSTOM_MOTOR_O(cust));
    rs485_host_model #(.DIV(SLOW)) host_u (.clk_i(clk), .rxd_o(rxd), .txd_i(txd),
        .txd_oe_i(txd_oe));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        tick(1);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        pen <= 1'b1;
        do tick(1); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        tick(30000);
        bad_count++;
        close_out;
    end
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(3);
        chk({baud, node, mb}, {3'h4, 5'h01, 1'b0}, "defaults");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h00, row_cfg[i]);
            tick(2);
            chk({baud, node}, row_exp[i], "rate or node");
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {19'h0, row_exp[i][4:0], 5'h0, row_exp[i][7:5]}, "cfg read");
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1, "unmapped read");
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hffff, "cutoff default");
        // host mode, node one: foreign packet is resent, own one is kept
        apb(1'b1, 8'h00, 32'h144);
        host_u.packet(8'h05, 8'ha5, SLOW);
        tick(12 * SLOW);
        chk(host_u.got_q.size(), 2, "forward count");
        chk({host_u.got_q[0], host_u.got_q[1]}, 16'h05a5, "forward bytes");
        host_u.packet(8'h01, 8'h3c, SLOW);
        tick(12 * SLOW);
        chk(host_u.got_q.size(), 2, "own packet resent");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h3c, "own byte");
        // modbus at its own faster rate, host rate left at 38400
        apb(1'b1, 8'h00, 32'h10164);
        tick(2);
        chk({mb, baud}, {1'b1, 3'h4}, "modbus mode");
        host_u.packet(8'h05, 8'h77, FAST);
        tick(12 * FAST);
        chk(host_u.got_q.size(), 2, "modbus resent");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h77, "modbus byte");
        // events: masked, unmasked, cleared by writing one
        apb(1'b0, 8'h18, 32'h0);
        chk(rd[1:0], 2'b11, "rx and forward events");
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, 8'h1c, 32'h1);
        tick(2);
        chk(irq, 1'b1, "unmasked irq");
        apb(1'b1, 8'h18, 32'h1);
        tick(2);
        chk(irq, 1'b0, "cleared irq");
        apb(1'b0, 8'h18, 32'h0);
        chk(rd[1:0], 2'b10, "other event kept");
        // motor settings locked while the drive runs
        drv <= 1'b1;
        tick(4);
        apb(1'b1, 8'h04, 32'h2201);
        tick(1);
        chk(mid, 8'h00, "change while enabled");
        apb(1'b0, 8'h18, 32'h0);
        chk(rd[3], 1'b1, "reject event");
        drv <= 1'b0;
        tick(4);
        apb(1'b1, 8'h04, 32'h2201);
        apb(1'b1, 8'h08, 32'h3e8);
        tick(1);
        chk(mid, 8'h22, "change while disabled");
        ohm <= 16'h03e9;
        tick(3);
        chk(ovt, 1'b1, "above cutoff");
        ohm <= 16'h03e8;
        tick(3);
        chk(ovt, 1'b0, "at cutoff");
        sw_open <= 1'b1;
        tick(4);
        chk(ovt, 1'b1, "switch open");
        apb(1'b1, 8'h04, 32'h2200);
        tick(2);
        chk(ovt, 1'b0, "sensor off");
        apb(1'b1, 8'h04, 32'h5502);
        tick(1);
        chk({cust, mid}, {1'b1, 8'h00}, "custom id");
        // second reset in mid-run
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(3);
        chk({baud, node, cust, mid}, {3'h4, 5'h01, 1'b0, 8'h00}, "reset again");
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h144, "cfg after reset");
        close_out;
    end
endmodule
`default_nettype wire
